// ### verilog/usx_core.sv
// serial transceiver: register file on an axi4-lite slave, asynchronous transmitter and receiver
//
// Behaviour
// - the serial port on bit gives the rx and tx pins to the port, and clearing it disables the port.
// - the nine-bit receive select bit picks nine-bit frames when set and eight-bit frames when clear.
// - single receive on is ignored in async and sync slave mode and clears itself after one sync master reception.
// - continuous receive on keeps reception running and overrides single receive on.
// - the framing fault flag is set by a bad stop bit and is updated when the next byte lands in the holding register.
// - the overrun fault flag is set on overrun and cleared only by clearing continuous receive on.
// - the transmit flag reaches the output only with its enable and both global and peripheral enables set; the transmit ready event needs only its mask bit.
// - with nine-bit transmit the ninth bit comes from the transmit ninth bit field, loaded before the byte.
// - setting transmit on also sets the transmit interrupt flag.
// - a write to the transmit holding register starts sending that byte.
// - a complete received word moves from the receive shift register into the receive holding register.
// - completing a reception sets the receive interrupt flag, which interrupts when its enable and both global and peripheral enables are set.
//
// Register access over AXI4-Lite was left to the implementer.
`include "usx_cfg.svh"
`timescale 1ns/10ps
module usx_core (
  input wire logic aclk, // system clock, 10 MHz
  input wire logic aresetn, // synchronous reset, low active
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic rx_in, // serial receive pin
  output logic tx_out, // serial transmit pin level
  output logic tx_oe, // transmit pin driven
  output logic irq // level interrupt
);
  // ==========================================================
  // state
  logic aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
  logic [9:0] awaddr_ff;
  logic [7:0] wdata_ff;
  logic wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [7:0] rdata_ff;
  logic [7:0] int_ctl_ff, pie_ff, rx_ctl_ff, tx_ctl_ff, baud_ff, tx_hold_ff, rx_hold_ff;
  logic tx_full_ff, rx_flag_ff, frame_bad_ff, overrun_ff, rx_ninth_ff;
  logic [3:0] evt_sts_ff, evt_mask_ff;
  usx_pkg::usx_ser_e tx_st_ff, rx_st_ff;
  logic [3:0] tx_tk_ff, tx_bit_ff, rx_tk_ff, rx_bit_ff;
  logic [8:0] tx_sh_ff, rx_sh_ff;
  logic rx_meta_ff, rx_sync_ff;
  logic tick;

  // ==========================================================
  // control bits
  wire port_on = rx_ctl_ff[`USX_B_PORT_ON];
  wire rx_nine = rx_ctl_ff[`USX_B_RX_NINE];
  wire single_rx = rx_ctl_ff[`USX_B_SINGLE_RX];
  wire cont_rx = rx_ctl_ff[`USX_B_CONT_RX];
  wire tx_on = tx_ctl_ff[`USX_B_TX_ON];
  wire tx_nine = tx_ctl_ff[`USX_B_TX_NINE];
  wire sync_master = tx_ctl_ff[`USX_B_SYNC_MODE] && tx_ctl_ff[`USX_B_CLK_SRC];
  wire shift_empty = (tx_st_ff == usx_pkg::SER_IDLE);
  wire tx_ready_flag = tx_on && !tx_full_ff;
  wire [7:0] pir = {2'b00, rx_flag_ff, tx_ready_flag, 4'h0};
  wire [7:0] rx_stat = {rx_ctl_ff[7:4], 1'b0, frame_bad_ff, overrun_ff, rx_ninth_ff};
  wire [7:0] tx_stat = {tx_ctl_ff[7:2], shift_empty, tx_ctl_ff[0]};

  // ==========================================================
  // axi4-lite handshakes and decode
  assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready = !w_hold_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = {24'h000000, rdata_ff};
  wire wr_go = aw_hold_ff && w_hold_ff && !bvalid_ff;
  wire rd_go = s_axi_arvalid && !rvalid_ff;
  wire [7:0] wr_idx = awaddr_ff[9:2];
  wire [7:0] rd_idx = s_axi_araddr[9:2];
  wire we = wr_go && wstrb_ff;
  wire we_int = we && (wr_idx == `USX_IDX_INT_CTRL);
  wire we_pie = we && (wr_idx == `USX_IDX_PIRQ_EN);
  wire we_rx = we && (wr_idx == `USX_IDX_RX_STAT);
  wire we_tx = we && (wr_idx == `USX_IDX_TX_STAT);
  wire we_hold = we && (wr_idx == `USX_IDX_TX_HOLD);
  wire we_baud = we && (wr_idx == `USX_IDX_BAUD_DIV);
  wire we_sts = we && (wr_idx == `USX_IDX_EVT_STS);
  wire we_msk = we && (wr_idx == `USX_IDX_EVT_MASK);
  wire wr_hit = (wr_idx == `USX_IDX_INT_CTRL) || (wr_idx == `USX_IDX_PIRQ_EN) || (wr_idx == `USX_IDX_RX_STAT) ||
                (wr_idx == `USX_IDX_TX_STAT) || (wr_idx == `USX_IDX_TX_HOLD) || (wr_idx == `USX_IDX_BAUD_DIV) ||
                (wr_idx == `USX_IDX_EVT_STS) || (wr_idx == `USX_IDX_EVT_MASK) || (wr_idx == `USX_IDX_PIRQ_FLAGS) ||
                (wr_idx == `USX_IDX_RX_HOLD);
  wire rd_hold = rd_go && (rd_idx == `USX_IDX_RX_HOLD);
  wire wr_hit_rd = (rd_idx == `USX_IDX_INT_CTRL) || (rd_idx == `USX_IDX_PIRQ_EN) || (rd_idx == `USX_IDX_RX_STAT) ||
                   (rd_idx == `USX_IDX_TX_STAT) || (rd_idx == `USX_IDX_BAUD_DIV) || (rd_idx == `USX_IDX_EVT_STS) ||
                   (rd_idx == `USX_IDX_EVT_MASK) || (rd_idx == `USX_IDX_PIRQ_FLAGS) || (rd_idx == `USX_IDX_RX_HOLD);
  wire rd_hit = wr_hit_rd || (rd_idx == `USX_IDX_TX_HOLD);
  wire [7:0] rd_val = (rd_idx == `USX_IDX_INT_CTRL) ? int_ctl_ff :
                      (rd_idx == `USX_IDX_PIRQ_FLAGS) ? pir :
                      (rd_idx == `USX_IDX_RX_STAT) ? rx_stat :
                      (rd_idx == `USX_IDX_RX_HOLD) ? rx_hold_ff :
                      (rd_idx == `USX_IDX_PIRQ_EN) ? pie_ff :
                      (rd_idx == `USX_IDX_TX_STAT) ? tx_stat :
                      (rd_idx == `USX_IDX_BAUD_DIV) ? baud_ff :
                      (rd_idx == `USX_IDX_EVT_STS) ? {4'h0, evt_sts_ff} :
                      (rd_idx == `USX_IDX_EVT_MASK) ? {4'h0, evt_mask_ff} : 8'h00;

  // ==========================================================
  // write channel: address and data latched in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      awaddr_ff <= 10'h000;
      wdata_ff <= `USX_RST_BYTE;
      wstrb_ff <= 1'b0;
      bresp_ff <= `USX_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr[9:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        wdata_ff <= s_axi_wdata[7:0];
        wstrb_ff <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? `USX_RESP_OKAY : `USX_RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) bvalid_ff <= 1'b0;
    end
  end

  // read channel: data registered one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= `USX_RST_BYTE;
      rresp_ff <= `USX_RESP_OKAY;
    end else if (rd_go) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_val;
      rresp_ff <= rd_hit ? `USX_RESP_OKAY : `USX_RESP_SLVERR;
    end else if (s_axi_rready) rvalid_ff <= 1'b0;
  end

  // ==========================================================
  // software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_ctl_ff <= `USX_RST_BYTE;
      pie_ff <= `USX_RST_BYTE;
      tx_ctl_ff <= `USX_RST_BYTE;
      baud_ff <= `USX_RST_BYTE;
      evt_mask_ff <= `USX_RST_EVT;
    end else begin
      if (we_int) int_ctl_ff <= wdata_ff & `USX_INT_WMASK;
      if (we_pie) pie_ff <= wdata_ff;
      if (we_tx) tx_ctl_ff <= wdata_ff & `USX_TX_WMASK;
      if (we_baud) baud_ff <= wdata_ff;
      if (we_msk) evt_mask_ff <= wdata_ff[3:0];
    end
  end

  // ==========================================================
  // baud ticks, shared by both directions
  usx_baud_gen u_baud (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(port_on),
    .high_speed(tx_ctl_ff[`USX_B_HIGH_SPEED]),
    .div(baud_ff),
    .tick(tick)
  );

  // ==========================================================
  // transmitter
  wire tx_run = port_on && tx_on;
  wire tx_load = tx_run && shift_empty && tx_full_ff;
  wire tx_bit_end = tick && (tx_tk_ff == `USX_TICKS_LAST);
  wire [3:0] tx_last = tx_nine ? `USX_BITS_NINE : `USX_BITS_EIGHT;
  assign tx_oe = port_on;
  assign tx_out = !port_on || (tx_st_ff == usx_pkg::SER_IDLE) || (tx_st_ff == usx_pkg::SER_STOP) ||
                  ((tx_st_ff == usx_pkg::SER_DATA) && tx_sh_ff[0]);

  // holding register: write fills it, the shifter empties it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_hold_ff <= `USX_RST_BYTE;
      tx_full_ff <= 1'b0;
    end else if (we_hold) begin
      tx_hold_ff <= wdata_ff;
      tx_full_ff <= 1'b1;
    end else if (tx_load) tx_full_ff <= 1'b0;
  end

  // frame sequencer, lsb first, ninth bit from the control field
  always_ff @(posedge aclk) begin
    if (!aresetn || !tx_run) begin
      tx_st_ff <= usx_pkg::SER_IDLE;
      tx_tk_ff <= 4'h0;
      tx_bit_ff <= 4'h0;
      tx_sh_ff <= 9'h1ff;
    end else begin
      if (tick) tx_tk_ff <= tx_tk_ff + 4'h1;
      unique case (tx_st_ff)
        usx_pkg::SER_IDLE: if (tx_load) begin
          tx_st_ff <= usx_pkg::SER_START;
          tx_tk_ff <= 4'h0;
          tx_sh_ff <= {tx_ctl_ff[`USX_B_TX_NINTH], tx_hold_ff};
        end
        usx_pkg::SER_START: if (tx_bit_end) begin
          tx_st_ff <= usx_pkg::SER_DATA;
          tx_bit_ff <= 4'h0;
        end
        usx_pkg::SER_DATA: if (tx_bit_end) begin
          tx_sh_ff <= {1'b1, tx_sh_ff[8:1]};
          tx_bit_ff <= tx_bit_ff + 4'h1;
          if (tx_bit_ff == tx_last) tx_st_ff <= usx_pkg::SER_STOP;
        end
        usx_pkg::SER_STOP: if (tx_bit_end) tx_st_ff <= usx_pkg::SER_IDLE;
        default: tx_st_ff <= usx_pkg::SER_IDLE;
      endcase
    end
  end

  // ==========================================================
  // receiver
  wire rx_run = port_on && (cont_rx || (sync_master && single_rx)) && !overrun_ff;
  wire rx_sample = tick && (rx_tk_ff == `USX_TICKS_LAST);
  wire [3:0] rx_last = rx_nine ? `USX_BITS_NINE : `USX_BITS_EIGHT;
  wire rx_done = (rx_st_ff == usx_pkg::SER_STOP) && rx_sample;
  wire rx_bad_stop = !rx_sync_ff;
  wire [7:0] rx_word = rx_nine ? rx_sh_ff[7:0] : rx_sh_ff[8:1];
  wire ovr_set = rx_done && rx_flag_ff;
  wire rx_land = rx_done && !rx_flag_ff;

  // pin synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
    end else begin
      rx_meta_ff <= rx_in;
      rx_sync_ff <= rx_meta_ff;
    end
  end

  // frame sequencer, start confirmed at mid bit
  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_run) begin
      rx_st_ff <= usx_pkg::SER_IDLE;
      rx_tk_ff <= 4'h0;
      rx_bit_ff <= 4'h0;
      rx_sh_ff <= 9'h000;
    end else begin
      if (tick) rx_tk_ff <= rx_tk_ff + 4'h1;
      unique case (rx_st_ff)
        usx_pkg::SER_IDLE: if (!rx_sync_ff) begin
          rx_st_ff <= usx_pkg::SER_START;
          rx_tk_ff <= 4'h0;
        end
        usx_pkg::SER_START: if (tick && rx_tk_ff == `USX_TICKS_MID) begin
          rx_st_ff <= rx_sync_ff ? usx_pkg::SER_IDLE : usx_pkg::SER_DATA;
          rx_tk_ff <= 4'h0;
          rx_bit_ff <= 4'h0;
        end
        usx_pkg::SER_DATA: if (rx_sample) begin
          rx_sh_ff <= {rx_sync_ff, rx_sh_ff[8:1]};
          rx_bit_ff <= rx_bit_ff + 4'h1;
          if (rx_bit_ff == rx_last) rx_st_ff <= usx_pkg::SER_STOP;
        end
        usx_pkg::SER_STOP: if (rx_sample) rx_st_ff <= usx_pkg::SER_IDLE;
        default: rx_st_ff <= usx_pkg::SER_IDLE;
      endcase
    end
  end

  // holding register and fault flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_hold_ff <= `USX_RST_BYTE;
      rx_flag_ff <= 1'b0;
      frame_bad_ff <= 1'b0;
      rx_ninth_ff <= 1'b0;
      overrun_ff <= 1'b0;
    end else begin
      if (rx_land) begin
        rx_hold_ff <= rx_word;
        rx_ninth_ff <= rx_nine && rx_sh_ff[8];
        frame_bad_ff <= rx_bad_stop;
        rx_flag_ff <= 1'b1;
      end else if (rd_hold) rx_flag_ff <= 1'b0;
      if (ovr_set) overrun_ff <= 1'b1;
      else if (!cont_rx) overrun_ff <= 1'b0;
    end
  end

  // receive control, single receive clears itself in sync master mode
  always_ff @(posedge aclk) begin
    if (!aresetn) rx_ctl_ff <= `USX_RST_BYTE;
    else if (we_rx) rx_ctl_ff <= wdata_ff & `USX_RX_WMASK;
    else if (rx_done && sync_master && !cont_rx) rx_ctl_ff[`USX_B_SINGLE_RX] <= 1'b0;
  end

  // ==========================================================
  // event status, write one to clear, a new event wins
  wire [3:0] evt_set;
  assign evt_set[`USX_E_RX_DONE] = rx_land;
  assign evt_set[`USX_E_TX_READY] = tx_load;
  assign evt_set[`USX_E_FRAME] = rx_land && rx_bad_stop;
  assign evt_set[`USX_E_OVERRUN] = ovr_set;
  always_ff @(posedge aclk) begin
    if (!aresetn) evt_sts_ff <= `USX_RST_EVT;
    else evt_sts_ff <= evt_set | (evt_sts_ff & ~(we_sts ? wdata_ff[3:0] : 4'h0));
  end

  // interrupt output
  wire periph_irq = |(pir & pie_ff);
  wire gate_on = int_ctl_ff[`USX_B_GLOBAL_IRQ] && int_ctl_ff[`USX_B_PERIPH_IRQ];
  assign irq = (gate_on && periph_irq) || |(evt_sts_ff & evt_mask_ff);

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_load;
    tx_run && shift_empty && tx_full_ff;
  endsequence
  sequence s_start_bit;
    (tx_st_ff == usx_pkg::SER_START) && !tx_out;
  endsequence

  chk_tx_start: assert property (s_load |=> s_start_bit) else $error("start bit missing after load");
  chk_tx_idle: assert property (port_on && shift_empty |-> tx_out && tx_oe) else $error("idle line low");
  chk_port_off: assert property (!port_on |-> !tx_oe && tx_out) else $error("pin driven while port off");
  chk_txrdy_rise: assert property ($rose(tx_on) && !tx_full_ff && !we_hold |-> pir[`USX_B_TX_IRQ])
    else $error("transmit flag not set by enable");
  chk_hold_clear: assert property (we_hold && tx_on |=> !pir[`USX_B_TX_IRQ] ##0 tx_full_ff)
    else $error("transmit flag still set after write");
  chk_irq_gate: assert property (irq && (evt_sts_ff & evt_mask_ff) == 4'h0 |-> gate_on && periph_irq)
    else $error("interrupt without enables");
  chk_rx_land: assert property (rx_land |=> rx_flag_ff && rx_hold_ff == $past(rx_word) &&
    frame_bad_ff == $past(rx_bad_stop))
    else $error("received word not moved to holding");
  chk_ovr_hold: assert property (overrun_ff && cont_rx |=> overrun_ff) else $error("overrun cleared with receive on");
  chk_ovr_clear: assert property (overrun_ff && !cont_rx |=> !overrun_ff) else $error("overrun not cleared");
  chk_single_rx: assert property (rx_done && sync_master && !cont_rx && !we_rx |=> !single_rx)
    else $error("single receive not cleared");
endmodule : usx_core

// ### verilog/usx_cfg.svh
// register map, field positions, reset values and timing counts of the serial transceiver
`ifndef USX_CFG_SVH
`define USX_CFG_SVH
// ==========================================================
// register indices, byte address is four times the index
`define USX_IDX_INT_CTRL 8'h0b
`define USX_IDX_PIRQ_FLAGS 8'h0c
`define USX_IDX_RX_STAT 8'h18
`define USX_IDX_TX_HOLD 8'h19
`define USX_IDX_RX_HOLD 8'h1a
`define USX_IDX_PIRQ_EN 8'h8c
`define USX_IDX_TX_STAT 8'h98
`define USX_IDX_BAUD_DIV 8'h99
`define USX_IDX_EVT_STS 8'hc0
`define USX_IDX_EVT_MASK 8'hc1
// ==========================================================
// field positions
`define USX_B_GLOBAL_IRQ 7
`define USX_B_PERIPH_IRQ 6
`define USX_B_RX_IRQ 5
`define USX_B_TX_IRQ 4
`define USX_B_PORT_ON 7
`define USX_B_RX_NINE 6
`define USX_B_SINGLE_RX 5
`define USX_B_CONT_RX 4
`define USX_B_FRAME_ERR 2
`define USX_B_OVERRUN 1
`define USX_B_RX_NINTH 0
`define USX_B_CLK_SRC 7
`define USX_B_TX_NINE 6
`define USX_B_TX_ON 5
`define USX_B_SYNC_MODE 4
`define USX_B_HIGH_SPEED 2
`define USX_B_SHIFT_EMPTY 1
`define USX_B_TX_NINTH 0
`define USX_E_RX_DONE 0
`define USX_E_TX_READY 1
`define USX_E_FRAME 2
`define USX_E_OVERRUN 3
// ==========================================================
// reset values and writable masks
`define USX_RST_BYTE 8'h00
`define USX_RST_EVT 4'h0
`define USX_RX_WMASK 8'hf0
`define USX_TX_WMASK 8'hf5
`define USX_INT_WMASK 8'hc0
// ==========================================================
// timing: sixteen baud ticks per bit, start checked at mid bit
`define USX_TICKS_LAST 4'hf
`define USX_TICKS_MID 4'h7
`define USX_BITS_EIGHT 4'h7
`define USX_BITS_NINE 4'h8
`define USX_RESP_OKAY 2'b00
`define USX_RESP_SLVERR 2'b10
`endif

// ### verilog/usx_pkg.sv
// state types of the serial transceiver
package usx_pkg;
  typedef enum logic [3:0] {
    SER_IDLE = 4'h1,
    SER_START = 4'h2,
    SER_DATA = 4'h4,
    SER_STOP = 4'h8
  } usx_ser_e;
endpackage : usx_pkg

// ### verilog/usx_baud_gen.sv
// baud tick generator, sixteen ticks per serial bit
`timescale 1ns/10ps
module usx_baud_gen (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, low active
  input wire logic run, // counts while high
  input wire logic high_speed, // divide by div+1 instead of 4*(div+1)
  input wire logic [7:0] div, // baud divisor
  output logic tick // one-cycle tick
);
  logic [9:0] cnt_ff;
  wire [9:0] reload = high_speed ? {2'b00, div} : {div, 2'b11};

  // ==========================================================
  // down counter, reloads on zero
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) cnt_ff <= 10'h000;
    else if (cnt_ff == 10'h000) cnt_ff <= reload;
    else cnt_ff <= cnt_ff - 10'h001;
  end

  assign tick = run && (cnt_ff == 10'h000);
endmodule : usx_baud_gen

// ### sim/usx_remote_node.sv
// remote serial node: drives the receive wire and decodes the transmit wire
`timescale 1ns/10ps
module usx_remote_node #(
  parameter int BIT_CYC = 16 // clock cycles per serial bit
) (
  input wire logic aclk, // system clock
  input wire logic line_in, // transmit wire level
  input wire logic nine, // decode a ninth bit
  output logic line_out // receive wire level
);
  logic [9:0] got_q[$]; // {stop, ninth, data}
  logic [9:0] w;
  initial line_out = 1'b1;
  // one frame: start, data lsb first, ninth, stop, then idle high
  task automatic send(input logic [7:0] d, input logic nb, input logic use9, input logic stop);
    logic [11:0] f;
    f = use9 ? {1'b1, stop, nb, d, 1'b0} : {2'b11, stop, d, 1'b0};
    for (int i = 0; i < 12; i++) begin
      line_out <= f[i];
      repeat (BIT_CYC) @(posedge aclk);
    end
    repeat (BIT_CYC) @(posedge aclk);
  endtask : send
  // decoder: waits out half a bit, then samples mid bit
  initial begin
    forever begin
      @(posedge aclk);
      if (line_in === 1'b0) begin
        repeat (BIT_CYC / 2) @(posedge aclk);
        w = '0;
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
          repeat (BIT_CYC) @(posedge aclk);
          w[i] = line_in;
        end
        repeat (BIT_CYC) @(posedge aclk);
        w[9] = line_in;
        got_q.push_back(w);
      end
    end
  end
endmodule : usx_remote_node

// ### sim/usx_core_tb_top.sv
// testbench of the serial transceiver against a remote node model
`include "usx_cfg.svh"
`timescale 1ns/10ps
module usx_core_tb_top;
  logic aclk, aresetn, awv, wv, bry, arv, rry, awr, wrd, bv, arr, rv, txo, toe, irq, rxl, txl, n9;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdt, rd;
  logic [3:0] wsb;
  logic [1:0] br, rr, rs;
  logic [7:0] b, c;
  logic [9:0] exp_q[$];
  int n_fail, num_checks;
  assign txl = toe ? txo : 1'b1; // pulled up while undriven
  usx_core DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(wsb), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .rx_in(rxl),
    .tx_out(txo), .tx_oe(toe), .irq(irq));
  usx_remote_node #(.BIT_CYC(16)) peer (.aclk(aclk), .line_in(txl), .nine(n9), .line_out(rxl));
  // 10 MHz clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // ==========================================================
  // bus tasks and compare
  function automatic logic [11:0] ad(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction : ad
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    @(posedge aclk);
    awa <= ad(i);
    wd <= {24'h0, d};
    wsb <= 4'h1 | 4'($urandom);
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    while (bv !== 1'b1) begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end
    rs = br;
    bry <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] i);
    @(posedge aclk);
    ara <= ad(i);
    arv <= 1'b1;
    rry <= 1'b1;
    while (rv !== 1'b1) begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end
    rd = rdt;
    rs = rr;
    rry <= 1'b0;
  endtask : rdr
  task automatic wait_rx;
    rd = '0;
    for (int n = 0; n < 150 && rd[`USX_B_RX_IRQ] !== 1'b1; n++) rdr(`USX_IDX_PIRQ_FLAGS);
  endtask : wait_rx
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  // watchdog
  initial begin
    repeat (30000) @(posedge aclk);
    n_fail++;
    test_done();
  end
  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] ix[10];
    logic [7:0] rc[4][4];
    ix = '{8'h0b, 8'h0c, 8'h18, 8'h19, 8'h1a, 8'h8c, 8'h98, 8'h99, 8'hc0, 8'hc1};
    rc = '{'{8'h90, 0, 1, 8'h90}, '{8'h90, 0, 0, 8'h94}, '{8'h90, 0, 1, 8'h90}, '{8'hd0, 1, 1, 8'hd1}};
    {aresetn, awv, wv, bry, arv, rry, n9, awa, ara, wd, wsb} = '0;
    b = $urandom(54);
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      rdr(ix[i]);
      chk("reset value", (ix[i] == `USX_IDX_TX_STAT) ? 32'h2 : 32'h0, rd);
    end
    rdr(8'h3f);
    chk("unmapped read", `USX_RESP_SLVERR, rs);
    wr(8'h3f, 8'hff);
    chk("unmapped write", `USX_RESP_SLVERR, rs);
    $display("test reset done");
    wr(`USX_IDX_BAUD_DIV, 8'h00);
    wr(`USX_IDX_TX_STAT, 8'h24);
    wr(`USX_IDX_RX_STAT, 8'h90);
    chk("tx_oe on", 1, toe);
    rdr(`USX_IDX_PIRQ_FLAGS);
    chk("tx flag", 32'h10, rd);
    wr(`USX_IDX_PIRQ_EN, 8'h10);
    wr(`USX_IDX_INT_CTRL, 8'hc0);
    chk("irq enabled", 1, irq);
    wr(`USX_IDX_INT_CTRL, 8'h80);
    chk("irq no periph", 0, irq);
    wr(`USX_IDX_INT_CTRL, 8'hc0);
    wr(`USX_IDX_PIRQ_EN, 8'h00);
    chk("irq no tx en", 0, irq);
    $display("test setup done");
    // two back-to-back bytes in each transmit mode
    for (int k = 0; k < 4; k++) begin
      n9 = k[1];
      wr(`USX_IDX_TX_STAT, k[1] ? (8'h64 | 8'(k[0])) : 8'h24);
      b = $urandom;
      c = $urandom;
      exp_q = '{{1'b1, k[1] & k[0], b}, {1'b1, k[1] & k[0], c}};
      wr(`USX_IDX_TX_HOLD, b);
      wr(`USX_IDX_TX_HOLD, c);
      for (int n = 0; n < 3000 && peer.got_q.size() < 2; n++) @(posedge aclk);
      for (int j = 0; j < 2; j++) chk("tx frame", exp_q[j], peer.got_q.pop_front());
      repeat (20) @(posedge aclk);
      rdr(`USX_IDX_TX_STAT);
      chk("shift empty", k[1] ? (32'h66 | k[0]) : 32'h26, rd);
    end
    rdr(`USX_IDX_EVT_STS);
    chk("tx event", 32'h2, rd);
    wr(`USX_IDX_EVT_MASK, 8'h02);
    chk("irq event", 1, irq);
    wr(`USX_IDX_EVT_STS, 8'h02);
    chk("irq cleared", 0, irq);
    wr(`USX_IDX_EVT_MASK, 8'h00);
    $display("test transmit done");
    wr(`USX_IDX_PIRQ_EN, 8'h20);
    for (int k = 0; k < 4; k++) begin
      wr(`USX_IDX_RX_STAT, rc[k][0]);
      b = $urandom;
      peer.send(b, rc[k][1][0], rc[k][1][0], rc[k][2][0]);
      wait_rx();
      chk("irq rx", 1, irq);
      rdr(`USX_IDX_RX_HOLD);
      chk("rx data", b, rd);
      chk("irq rx read", 0, irq);
      rdr(`USX_IDX_RX_STAT);
      chk("rx status", rc[k][3], rd);
    end
    $display("test receive done");
    wr(`USX_IDX_RX_STAT, 8'h90);
    b = $urandom;
    peer.send(b, 0, 0, 1);
    peer.send(~b, 0, 0, 1);
    rdr(`USX_IDX_RX_STAT);
    chk("overrun set", 32'h92, rd);
    rdr(`USX_IDX_RX_HOLD);
    chk("first kept", b, rd);
    wr(`USX_IDX_RX_STAT, 8'h80);
    rdr(`USX_IDX_RX_STAT);
    chk("overrun clear", 32'h80, rd);
    $display("test overrun done");
    wr(`USX_IDX_TX_STAT, 8'h94);
    wr(`USX_IDX_RX_STAT, 8'ha0);
    b = $urandom;
    peer.send(b, 0, 0, 1);
    wait_rx();
    rdr(`USX_IDX_RX_STAT);
    chk("single self clear", 32'h80, rd);
    wr(`USX_IDX_RX_STAT, 8'h00);
    chk("tx_oe off", 0, toe);
    chk("tx idle", 1, txo);
    $display("test mode done");
    test_done();
  end
endmodule : usx_core_tb_top
